// *** nrp_top.sv ***
// network request port: start-up switch capture, request lines, AXI4-Lite registers
`timescale 1ns/1ps
`include "nrp_consts.svh"
module nrp_top
	import nrp_pkg::*;
#(
	parameter int ADDR_W = 12,
	parameter int BAUD_DIV = `NRP_BAUD_DIV
)
(
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_variant_dc,
	input wire logic [1:0] i_function_switch_ac,
	input wire logic [3:0] i_function_switch_dc,
	input wire logic [3:0] i_address_selector,
	input wire logic [3:0] i_rate_selector,
	input wire logic [ADDR_W-1:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire logic [ADDR_W-1:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	output logic o_exec_valid,
	output logic [1:0] o_exec_line,
	output logic [1:0] o_exec_kind,
	output logic [63:0] o_exec_cmd,
	input wire logic i_exec_done,
	input wire logic [31:0] i_exec_rdata,
	output logic o_modbus_mode,
	output logic [4:0] o_unit_addr,
	output logic o_addr_error,
	output logic o_term_enable,
	output logic o_rate_error,
	output logic o_baud_tick
);
	localparam int NL = `NRP_NUM_LINES;
	localparam int NW = `NRP_NUM_WORDS;

	// captured start-up configuration
	logic cfg_taken;
	logic cfg_proto_on;
	logic cfg_addr_ext;
	logic cfg_term;
	logic [3:0] cfg_addr;
	logic [3:0] cfg_rate;

	// dc switch bit 3 (index 2) is never looked at
	wire sw_addr_ext = i_variant_dc ? i_function_switch_dc[0] : i_function_switch_ac[0];
	wire sw_proto = i_variant_dc ? i_function_switch_dc[1] : i_function_switch_ac[1];
	wire sw_term = i_variant_dc & i_function_switch_dc[3];

	// one capture after reset release; later switch moves are ignored
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			cfg_taken <= 1'b0;
			cfg_proto_on <= 1'b0;
			cfg_addr_ext <= 1'b0;
			cfg_term <= 1'b0;
			cfg_addr <= 4'h0;
			cfg_rate <= `NRP_RATE_DEFAULT;
		end
		else if (!cfg_taken)
		begin
			cfg_taken <= 1'b1;
			cfg_proto_on <= sw_proto;
			cfg_addr_ext <= sw_addr_ext;
			cfg_term <= sw_term;
			cfg_addr <= i_address_selector;
			cfg_rate <= i_rate_selector;
		end
	end

	assign o_modbus_mode = cfg_proto_on;
	assign o_unit_addr = {cfg_addr_ext, cfg_addr};
	assign o_addr_error = cfg_addr_ext;
	assign o_term_enable = cfg_term;
	assign o_rate_error = (cfg_rate >= `NRP_RATE_FIRST_BAD);

	// link bit-rate enable; only position 7 has a known rate
	logic [7:0] baud_cnt;
	wire baud_run = cfg_taken && (cfg_rate == `NRP_RATE_DEFAULT);
	wire baud_wrap = (baud_cnt == 8'(BAUD_DIV - 1));
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			baud_cnt <= 8'h00;
			o_baud_tick <= 1'b0;
		end
		else
		begin
			baud_cnt <= (!baud_run || baud_wrap) ? 8'h00 : baud_cnt + 8'h01;
			o_baud_tick <= baud_run && baud_wrap;
		end
	end

	// software registers
	logic [15:0] ctrl;
	logic [15:0] host_write_word [NW];
	logic aw_held;
	logic w_held;
	logic [ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;

	assign o_awready = !aw_held && !o_bvalid;
	assign o_wready = !w_held && !o_bvalid;
	wire wr_fire = aw_held && w_held && !o_bvalid;
	wire [9:0] wr_idx = aw_addr[11:2];
	wire wr_is_word = (wr_idx >= `NRP_IDX_WR_BASE) && (wr_idx < `NRP_IDX_WR_BASE + 10'(NW));
	wire wr_is_rd = (wr_idx < `NRP_IDX_RD_BASE + 10'(NW));
	wire wr_is_ctrl = (wr_idx == `NRP_IDX_CTRL);
	wire wr_is_ro = (wr_idx == `NRP_IDX_STATUS) || (wr_idx == `NRP_IDX_CONFIG) || wr_is_rd;
	wire [3:0] wr_word_sel = wr_idx[3:0];
	wire [15:0] wr_mask = {{8{w_strb[1]}}, {8{w_strb[0]}}};
	wire [1:0] wr_resp = (wr_is_word || wr_is_ctrl) ? `NRP_RESP_OKAY :
		(wr_is_ro ? `NRP_RESP_SLVERR : `NRP_RESP_DECERR);

	// address and data are taken in either order, then applied together
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			o_bvalid <= 1'b0;
			o_bresp <= `NRP_RESP_OKAY;
		end
		else
		begin
			if (i_awvalid && o_awready)
			begin
				aw_held <= 1'b1;
				aw_addr <= i_awaddr;
			end
			if (i_wvalid && o_wready)
			begin
				w_held <= 1'b1;
				w_data <= i_wdata;
				w_strb <= i_wstrb;
			end
			if (wr_fire)
			begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				o_bvalid <= 1'b1;
				o_bresp <= wr_resp;
			end
			else if (o_bvalid && i_bready)
			begin
				o_bvalid <= 1'b0;
			end
		end
	end

	// control and host write words
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			ctrl <= `NRP_CTRL_RESET;
		end
		else if (wr_fire && wr_is_ctrl)
		begin
			ctrl <= (ctrl & ~wr_mask) | (w_data[15:0] & wr_mask);
		end
	end

	genvar gw;
	generate
		for (gw = 0; gw < NW; gw++)
		begin : g_word
			always_ff @(posedge i_ref_clk or negedge i_rst_n)
			begin
				if (!i_rst_n)
				begin
					host_write_word[gw] <= `NRP_WORD_RESET;
				end
				else if (wr_fire && wr_is_word && wr_word_sel == 4'(gw))
				begin
					host_write_word[gw] <= (host_write_word[gw] & ~wr_mask) | (w_data[15:0] & wr_mask);
				end
			end
		end
	endgenerate

	// request lines; converter side is shut while in Modbus mode
	wire fix_mode = ctrl[`NRP_CTRL_FIX_BIT];
	wire port_on = cfg_taken && !cfg_proto_on;
	logic [NL-1:0] line_done;
	logic [NL-1:0] line_busy;
	logic [NL-1:0] line_exec;
	logic [63:0] line_res [NL];
	logic [1:0] owner;
	logic owner_busy;
	wire [15:0] host_read_word [NW];

	genvar gl;
	generate
		for (gl = 0; gl < NL; gl++)
		begin : g_line
			nrp_req_if rq ();
			// fixation drives line 0 from write request, line 2 from read request
			wire fix_req = (gl == 0) ? ctrl[`NRP_CTRL_WRREQ_BIT] :
				((gl == 2) ? ctrl[`NRP_CTRL_RDREQ_BIT] : 1'b0);
			assign rq.req = port_on && (fix_mode ? fix_req : ctrl[`NRP_CTRL_DREQ_LSB + gl]);
			assign rq.kind = fix_mode ? ((gl == 0) ? NRP_KIND_WRITE : NRP_KIND_READ) :
				((gl < 2) ? NRP_KIND_DATA : NRP_KIND_MONITOR);
			// line n takes write words 100+4n..103+4n
			assign rq.cmd = {host_write_word[4*gl+3], host_write_word[4*gl+2],
				host_write_word[4*gl+1], host_write_word[4*gl]};
			assign rq.exec_done = i_exec_done && owner_busy && (owner == 2'(gl));
			assign rq.exec_rdata = i_exec_rdata;
			assign line_done[gl] = rq.done;
			assign line_busy[gl] = rq.busy;
			assign line_exec[gl] = rq.exec_req;
			assign line_res[gl] = rq.res;
			// line n answers in read words 4n..4n+3
			assign host_read_word[4*gl] = rq.res[15:0];
			assign host_read_word[4*gl+1] = rq.res[31:16];
			assign host_read_word[4*gl+2] = rq.res[47:32];
			assign host_read_word[4*gl+3] = rq.res[63:48];
			nrp_req_engine u_engine
			(
				.i_ref_clk(i_ref_clk),
				.i_rst_n(i_rst_n),
				.bus(rq.engine)
			);
		end
	endgenerate

	// fixed priority back-end arbiter; low line wins, grant held until done
	wire [1:0] pick = line_exec[0] ? 2'h0 : (line_exec[1] ? 2'h1 : (line_exec[2] ? 2'h2 : 2'h3));
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			owner <= 2'h0;
			owner_busy <= 1'b0;
		end
		else if (!owner_busy && |line_exec)
		begin
			owner <= pick;
			owner_busy <= 1'b1;
		end
		else if (owner_busy && i_exec_done)
		begin
			owner_busy <= 1'b0;
		end
	end

	// command words sit in flops of the engine; kind/cmd chosen by owner
	logic [1:0] kind_sel;
	logic [63:0] cmd_sel;
	always_comb
	begin
		kind_sel = 2'h0;
		cmd_sel = 64'h0000000000000000;
		case (owner)
			2'h0:
			begin
				kind_sel = g_line[0].rq.kind;
				cmd_sel = g_line[0].u_engine.cmd_hold;
			end
			2'h1:
			begin
				kind_sel = g_line[1].rq.kind;
				cmd_sel = g_line[1].u_engine.cmd_hold;
			end
			2'h2:
			begin
				kind_sel = g_line[2].rq.kind;
				cmd_sel = g_line[2].u_engine.cmd_hold;
			end
			default:
			begin
				kind_sel = g_line[3].rq.kind;
				cmd_sel = g_line[3].u_engine.cmd_hold;
			end
		endcase
	end
	assign o_exec_valid = owner_busy;
	assign o_exec_line = owner;
	assign o_exec_kind = kind_sel;
	assign o_exec_cmd = cmd_sel;

	// read path; one beat, answered the cycle after the address
	wire [9:0] rd_idx = i_araddr[11:2];
	wire rd_is_rd = (rd_idx < `NRP_IDX_RD_BASE + 10'(NW));
	wire rd_is_word = (rd_idx >= `NRP_IDX_WR_BASE) && (rd_idx < `NRP_IDX_WR_BASE + 10'(NW));
	wire [31:0] status_word = {23'h000000, cfg_proto_on, line_busy, line_done};
	wire [31:0] config_word = {19'h00000, i_variant_dc, o_rate_error, cfg_term, cfg_proto_on,
		cfg_rate, cfg_addr_ext, cfg_addr};
	wire rd_known = rd_is_rd || rd_is_word || (rd_idx == `NRP_IDX_CTRL) ||
		(rd_idx == `NRP_IDX_STATUS) || (rd_idx == `NRP_IDX_CONFIG);
	wire [31:0] rd_value = rd_is_rd ? {16'h0000, host_read_word[rd_idx[3:0]]} :
		rd_is_word ? {16'h0000, host_write_word[rd_idx[3:0]]} :
		(rd_idx == `NRP_IDX_CTRL) ? {16'h0000, ctrl} :
		(rd_idx == `NRP_IDX_STATUS) ? status_word :
		(rd_idx == `NRP_IDX_CONFIG) ? config_word : 32'h00000000;
	assign o_arready = !o_rvalid;

	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_rvalid <= 1'b0;
			o_rdata <= 32'h00000000;
			o_rresp <= `NRP_RESP_OKAY;
		end
		else if (i_arvalid && o_arready)
		begin
			o_rvalid <= 1'b1;
			o_rdata <= rd_value;
			o_rresp <= rd_known ? `NRP_RESP_OKAY : `NRP_RESP_DECERR;
		end
		else if (o_rvalid && i_rready)
		begin
			o_rvalid <= 1'b0;
		end
	end
endmodule

// *** nrp_consts.svh ***
// constants for the network request port: offsets, fields, resets, timing
`ifndef NRP_CONSTS_SVH
`define NRP_CONSTS_SVH
`define NRP_IDX_RD_BASE 10'h000
`define NRP_IDX_WR_BASE 10'h100
`define NRP_IDX_CTRL 10'h140
`define NRP_IDX_STATUS 10'h141
`define NRP_IDX_CONFIG 10'h142
`define NRP_NUM_WORDS 16
`define NRP_NUM_LINES 4
`define NRP_CTRL_DREQ_LSB 0
`define NRP_CTRL_WRREQ_BIT 4
`define NRP_CTRL_RDREQ_BIT 5
`define NRP_CTRL_FIX_BIT 8
`define NRP_CTRL_RESET 16'h0000
`define NRP_WORD_RESET 16'h0000
`define NRP_RATE_DEFAULT 4'h7
`define NRP_RATE_FIRST_BAD 4'h8
`define NRP_CLK_HZ 40000000
`define NRP_LINK_BPS 625000
`define NRP_BAUD_DIV (`NRP_CLK_HZ / `NRP_LINK_BPS)
`define NRP_RESP_OKAY 2'h0
`define NRP_RESP_SLVERR 2'h2
`define NRP_RESP_DECERR 2'h3
`endif

// *** nrp_pkg.sv ***
// types shared by the network request port modules
package nrp_pkg;
	typedef enum logic [1:0]
	{
		NRP_IDLE = 2'h0,
		NRP_EXEC = 2'h1,
		NRP_DONE = 2'h3
	} nrp_state_t;
	typedef enum logic [1:0]
	{
		NRP_KIND_DATA = 2'h0,
		NRP_KIND_MONITOR = 2'h1,
		NRP_KIND_WRITE = 2'h2,
		NRP_KIND_READ = 2'h3
	} nrp_kind_t;
endpackage

// *** nrp_req_if.sv ***
// carrier between the port top and one request-line engine
`timescale 1ns/1ps
interface nrp_req_if;
	import nrp_pkg::*;
	logic req;
	nrp_kind_t kind;
	logic [63:0] cmd;
	logic exec_req;
	logic exec_done;
	logic [31:0] exec_rdata;
	logic done;
	logic busy;
	logic [63:0] res;
	modport engine (input req, input kind, input cmd, input exec_done, input exec_rdata,
		output exec_req, output done, output busy, output res);
	modport top (output req, output kind, output cmd, output exec_done, output exec_rdata,
		input exec_req, input done, input busy, input res);
endinterface

// *** nrp_req_engine.sv ***
// one request line: capture command group, execute, hold result until release
`timescale 1ns/1ps
module nrp_req_engine
	import nrp_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	nrp_req_if.engine bus
);
	nrp_state_t state;
	nrp_state_t next_state;
	logic [63:0] cmd_hold;
	logic [63:0] res;
	logic done;

	// next state: request taken, executed, then released by the host
	always_comb
	begin
		next_state = state;
		case (state)
			NRP_IDLE:
			begin
				if (bus.req)
				begin
					next_state = NRP_EXEC;
				end
			end
			NRP_EXEC:
			begin
				if (bus.exec_done)
				begin
					next_state = NRP_DONE;
				end
			end
			NRP_DONE:
			begin
				if (!bus.req)
				begin
					next_state = NRP_IDLE;
				end
			end
			default: next_state = NRP_IDLE;
		endcase
	end

	// state and captured command words
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			state <= NRP_IDLE;
			cmd_hold <= 64'h0000000000000000;
		end
		else
		begin
			state <= next_state;
			if (state == NRP_IDLE && bus.req)
			begin
				cmd_hold <= bus.cmd; // words frozen so host edits mid-request do no harm
			end
		end
	end

	// result group echoes code and address, data from the back end
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			res <= 64'h0000000000000000;
			done <= 1'b0;
		end
		else
		begin
			if (state == NRP_EXEC && bus.exec_done)
			begin
				res <= {bus.exec_rdata, cmd_hold[31:0]};
				done <= 1'b1;
			end
			else if (state == NRP_DONE && !bus.req)
			begin
				done <= 1'b0;
			end
		end
	end

	assign bus.exec_req = (state == NRP_EXEC);
	assign bus.done = done;
	assign bus.busy = (state != NRP_IDLE);
	assign bus.res = res;
endmodule

// *** nrp_checker.sv ***
// assertions on the network request port pins
`timescale 1ns/1ps
module nrp_checker
#(
	parameter int BAUD_DIV = 64
)
(
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic [3:0] i_address_selector,
	input wire logic i_awvalid,
	input wire logic o_awready,
	input wire logic i_wvalid,
	input wire logic o_wready,
	input wire logic o_bvalid,
	input wire logic [1:0] o_bresp,
	input wire logic i_bready,
	input wire logic i_arvalid,
	input wire logic o_arready,
	input wire logic o_rvalid,
	input wire logic [31:0] o_rdata,
	input wire logic i_rready,
	input wire logic o_exec_valid,
	input wire logic [1:0] o_exec_line,
	input wire logic [1:0] o_exec_kind,
	input wire logic i_exec_done,
	input wire logic o_modbus_mode,
	input wire logic [4:0] o_unit_addr,
	input wire logic o_addr_error,
	input wire logic o_rate_error,
	input wire logic o_baud_tick
);
	logic [1:0] seen;
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	// config lands after the capture edge, so skip the first edges
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			seen <= 2'h0;
		else if (seen != 2'h3)
			seen <= seen + 2'h1;
	end
	cfg_hold_a: assert property (seen == 2'h3 |=> $stable({o_unit_addr, o_modbus_mode}))
		else $error("config changed after capture");
	// selector value seen at the capture edge must be the one reported
	addr_flag_a: assert property (seen == 2'h1 |-> o_addr_error == o_unit_addr[4] &&
		o_unit_addr[3:0] == $past(i_address_selector))
		else $error("unit address not taken from selector");
	tick_rate_a: assert property (o_baud_tick |-> !o_rate_error ##BAUD_DIV o_baud_tick)
		else $error("baud tick period wrong");
	modbus_block_a: assert property (o_modbus_mode |-> !o_exec_valid)
		else $error("command issued in modbus mode");
	exec_end_a: assert property (o_exec_valid && i_exec_done |=> !o_exec_valid)
		else $error("command stays pending after done");
	line_kind_a: assert property (o_exec_valid |-> o_exec_kind[0] == o_exec_line[1])
		else $error("command kind does not match line");
	wr_resp_a: assert property (i_awvalid && o_awready && i_wvalid && o_wready |-> ##2 o_bvalid)
		else $error("write response late");
	b_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
		else $error("write response dropped");
	rd_resp_a: assert property (i_arvalid && o_arready |=> o_rvalid && !o_arready)
		else $error("read response late");
	r_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
		else $error("read data dropped");
	cover property (o_exec_valid && i_exec_done);
	cover property (o_bvalid && o_bresp == 2'h3);
	cover property (o_baud_tick);
endmodule
bind nrp_top nrp_checker #(.BAUD_DIV(BAUD_DIV)) u_nrp_checker (.*);

// *** nrp_backend.sv ***
// behavioural back end that executes port commands
`timescale 1ns/1ps
module nrp_backend
(
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_exec_valid,
	input wire logic [63:0] i_exec_cmd,
	input wire logic i_slow,
	output logic o_exec_done,
	output logic [31:0] o_exec_rdata
);
	logic [3:0] wait_cnt;
	logic busy;
	// one done pulse per command; slow mode stalls the answer
	always @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			wait_cnt <= 4'h0;
			busy <= 1'b0;
			o_exec_done <= 1'b0;
			o_exec_rdata <= 32'hA5A5_5A5A;
		end
		else
		begin
			o_exec_done <= 1'b0;
			o_exec_rdata <= ~o_exec_rdata; // never leaves old data standing
			if (i_exec_valid && !busy)
			begin
				if (wait_cnt == (i_slow ? 4'h6 : 4'h0))
				begin
					o_exec_done <= 1'b1;
					o_exec_rdata <= i_exec_cmd[63:32];
					busy <= 1'b1;
				end
				else
					wait_cnt <= wait_cnt + 4'h1;
			end
			else if (!i_exec_valid)
			begin
				busy <= 1'b0;
				wait_cnt <= 4'h0;
			end
		end
	end
endmodule

// *** testbench.sv ***
// self-checking bench for the network request port
`timescale 1ns/1ps
module testbench;
	logic clk, rst_n, dc, awv, wv, brdy, arv, rrdy, slow, done, fx;
	logic awr, wr, bv, arr, rv, xv, mb, ae, te, re;
	logic [1:0] fac, bresp, rresp, xk;
	logic [3:0] dsw, sel, rate;
	logic [4:0] ua;
	logic [11:0] awa, ara;
	logic [31:0] wd, xrd, rdv, rdata;
	logic [63:0] xcmd;
	logic [65:0] n;
	logic [65:0] rq[$];
	logic [1:0] bq[$];
	logic [15:0] wrd[16];
	int num_errors, total_checks, cycles, seed;
	nrp_top u_nrp_top (.i_ref_clk(clk), .i_rst_n(rst_n), .i_variant_dc(dc),
		.i_function_switch_ac(fac), .i_function_switch_dc(dsw), .i_address_selector(sel),
		.i_rate_selector(rate), .i_awaddr(awa), .i_awvalid(awv), .o_awready(awr),
		.i_wdata(wd), .i_wstrb(4'hF), .i_wvalid(wv), .o_wready(wr), .o_bresp(bresp),
		.o_bvalid(bv), .i_bready(brdy), .i_araddr(ara), .i_arvalid(arv), .o_arready(arr),
		.o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rv), .i_rready(rrdy),
		.o_exec_valid(xv), .o_exec_line(), .o_exec_kind(xk), .o_exec_cmd(xcmd),
		.i_exec_done(done), .i_exec_rdata(xrd), .o_modbus_mode(mb), .o_unit_addr(ua),
		.o_addr_error(ae), .o_term_enable(te), .o_rate_error(re), .o_baud_tick());
	nrp_backend u_nrp_backend (.i_ref_clk(clk), .i_rst_n(rst_n), .i_exec_valid(xv),
		.i_exec_cmd(xcmd), .i_slow(slow), .o_exec_done(done), .o_exec_rdata(xrd));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// write: both channels offered together, bready only once bvalid shows
	task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
		logic aw_open;
		logic w_open;
		aw_open = 1'b1;
		w_open = 1'b1;
		bq.push_back(r);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		while (aw_open || w_open)
		begin
			@(negedge clk);
			aw_open = aw_open && !awr;
			w_open = w_open && !wr;
			@(posedge clk);
			awv <= aw_open;
			wv <= w_open;
		end
		do @(negedge clk); while (!bv);
		@(posedge clk);
		brdy <= 1'b1;
		@(posedge clk);
		brdy <= 1'b0;
	endtask
	task automatic axr(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
		input logic [1:0] r);
		rq.push_back({m, r, e});
		ara <= a;
		arv <= 1'b1;
		do @(negedge clk); while (!arr);
		@(posedge clk);
		arv <= 1'b0;
		rrdy <= 1'b1;
		do @(negedge clk); while (!rv);
		@(posedge clk);
		rdv = rdata;
		rrdy <= 1'b0;
	endtask
	task automatic poll(input logic [3:0] w);
		do axr(12'h504, 32'h0, 32'h0, 2'h0); while (rdv[3:0] !== w);
		axr(12'h504, 32'hF, {28'h0, w}, 2'h0);
	endtask
	task automatic words(input int b);
		for (int i = b; i < b + 4; i++)
			axr(12'(4 * i), 32'hFFFF, {16'h0, wrd[i]}, 2'h0);
	endtask
	task automatic boot(input logic d, input logic [1:0] a, input logic [3:0] s,
		input logic [3:0] r);
		logic x;
		logic p;
		logic [3:0] v;
		v = 4'($random(seed));
		x = d ? s[0] : a[0];
		p = d ? s[1] : a[1];
		dc <= d;
		fac <= a;
		dsw <= s;
		sel <= v;
		rate <= r;
		rst_n <= 1'b0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		chk({23'h0, ua, mb, re, te, ae}, {23'h0, x, v, p, r >= 4'h8, d & s[3], x});
		fac <= ~a;
		dsw <= ~s;
		sel <= ~v;
		rate <= ~r;
		repeat (4) @(posedge clk);
		chk({27'h0, ua}, {27'h0, x, v});
		axr(12'h508, 32'hFFFF_FFFF, {19'h0, d, r >= 4'h8, d & s[3], p, r, x, v}, 2'h0);
	endtask
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// results are matched against the oldest note
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (rv && rrdy)
		begin
			n = rq.pop_front();
			chk(rdata & n[65:34], n[31:0] & n[65:34]);
			chk({30'h0, rresp}, {30'h0, n[33:32]});
		end
		if (bv && brdy)
			chk({30'h0, bresp}, {30'h0, bq.pop_front()});
		// kind bit 1 marks a fixation command at the back end
		if (xv && done)
			chk({31'h0, xk[1]}, {31'h0, fx});
		if (cycles == 40000)
		begin
			num_errors++;
			complete_run();
		end
	end
	initial
	begin
		{rst_n, awv, wv, brdy, arv, rrdy, slow, fx, awa, ara, wd} = '0;
		{dc, fac, dsw, sel, rate, cycles, num_errors, total_checks} = '0;
		seed = 32'h09A9;
		boot(1'b0, 2'h0, 4'h0, 4'h7);
		for (int i = 0; i < 16; i++)
		begin
			// converter set for two units only addresses units 0 and 1
			wrd[i] = (i % 4 == 1) ? 16'(i / 4 % 2) : 16'($random(seed));
			axw(12'(12'h400 + 4 * i), {16'h0, wrd[i]}, 2'h0);
		end
		axw(12'h500, 32'hF, 2'h0);
		poll(4'hF);
		words(0);
		words(4);
		words(8);
		words(12);
		axw(12'h500, 32'h0, 2'h0);
		poll(4'h0);
		slow <= 1'b1;
		fx <= 1'b1;
		axw(12'h500, 32'h110, 2'h0);
		poll(4'h1);
		words(0);
		axw(12'h500, 32'h100, 2'h0);
		poll(4'h0);
		axw(12'h500, 32'h120, 2'h0);
		poll(4'h4);
		words(8);
		axw(12'h500, 32'h0, 2'h0);
		poll(4'h0);
		axw(12'h000, 32'h1234, 2'h2);
		axw(12'h504, 32'h1, 2'h2);
		axw(12'h600, 32'h1, 2'h3);
		axr(12'h600, 32'hFFFF_FFFF, 32'h0, 2'h3);
		boot(1'b1, 2'h0, 4'hE, 4'h8);
		axw(12'h500, 32'h1, 2'h0);
		repeat (20) @(posedge clk);
		axr(12'h504, 32'hF, 32'h0, 2'h0);
		boot(1'b0, 2'h1, 4'h0, 4'h7);
		repeat (140) @(posedge clk);
		complete_run();
	end
endmodule
